// >>> core/tmw_pkg.sv
package tmw_pkg;

   // ==========================================================
   // Register map (byte addresses on APB)
   // ==========================================================
   localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
   localparam logic [7:0] ADDR_MATCH_A   = 8'h08;
   localparam logic [7:0] ADDR_MATCH_B   = 8'h0C;
   localparam logic [7:0] ADDR_CAPTURE   = 8'h10;
   localparam logic [7:0] ADDR_COUNTER   = 8'h14;
   localparam logic [7:0] ADDR_INT_STAT  = 8'h18;
   localparam logic [7:0] ADDR_INT_MASK  = 8'h1C;
   localparam logic [7:0] ADDR_PIN_DIR   = 8'h20;

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int         CA_MODE_A_LSB  = 6;
   localparam int         CA_MODE_B_LSB  = 4;
   localparam int         CB_HIGH_LSB    = 3;
   localparam logic [7:0] CTRL_A_WMASK   = 8'hF3;
   localparam logic [7:0] CTRL_A_RESET   = 8'h00;
   localparam logic [1:0] CTRL_B_RESET   = 2'h0;
   localparam logic [2:0] IRQ_RESET      = 3'h0;
   localparam int         IRQ_WRAP       = 0;
   localparam int         IRQ_MATCH_A    = 1;
   localparam logic [15:0] CNT_MAX       = 16'hFFFF;
   localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
   localparam logic [15:0] TOP_8BIT      = 16'h00FF;
   localparam logic [15:0] TOP_9BIT      = 16'h01FF;
   localparam logic [15:0] TOP_10BIT     = 16'h03FF;

   // ==========================================================
   // Mode decode types
   // ==========================================================
   typedef enum logic [1:0] {TOP_FIXED = 2'h0, TOP_MATCH_A = 2'h1, TOP_CAPTURE = 2'h2} tmw_top_src_t;
   typedef enum logic [1:0] {EV_NOW = 2'h0, EV_TOP = 2'h1, EV_BOTTOM = 2'h2, EV_MAX = 2'h3} tmw_event_t;
   typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} tmw_dir_t;

   typedef struct packed {
      logic         nonpwm;    // Normal or clear-on-match
      logic         fast;      // Single-slope PWM
      logic         dual;      // Dual-slope PWM
      logic         toggle_ok; // Channel A may toggle in this PWM mode
      tmw_top_src_t top_src;
      logic [15:0]  top_fixed;
      tmw_event_t   update_at;
      tmw_event_t   wrap_at;
   } tmw_mode_t;

   // Decode of the 4-bit waveform mode
   function automatic tmw_mode_t tmw_decode(input logic [3:0] m);
      tmw_mode_t d;
      d = '{1'b1, 1'b0, 1'b0, 1'b0, TOP_FIXED, CNT_MAX, EV_NOW, EV_MAX};
      unique case (m)
         4'h0, 4'hD: d = d;
         4'h1: d = '{1'b0, 1'b0, 1'b1, 1'b0, TOP_FIXED, TOP_8BIT, EV_TOP, EV_BOTTOM};
         4'h2: d = '{1'b0, 1'b0, 1'b1, 1'b0, TOP_FIXED, TOP_9BIT, EV_TOP, EV_BOTTOM};
         4'h3: d = '{1'b0, 1'b0, 1'b1, 1'b0, TOP_FIXED, TOP_10BIT, EV_TOP, EV_BOTTOM};
         4'h4: d.top_src = TOP_MATCH_A;
         4'h5: d = '{1'b0, 1'b1, 1'b0, 1'b0, TOP_FIXED, TOP_8BIT, EV_TOP, EV_TOP};
         4'h6: d = '{1'b0, 1'b1, 1'b0, 1'b0, TOP_FIXED, TOP_9BIT, EV_TOP, EV_TOP};
         4'h7: d = '{1'b0, 1'b1, 1'b0, 1'b0, TOP_FIXED, TOP_10BIT, EV_TOP, EV_TOP};
         4'h8: d = '{1'b0, 1'b0, 1'b1, 1'b1, TOP_CAPTURE, CNT_MAX, EV_BOTTOM, EV_BOTTOM};
         4'h9: d = '{1'b0, 1'b0, 1'b1, 1'b1, TOP_MATCH_A, CNT_MAX, EV_BOTTOM, EV_BOTTOM};
         4'hA: d = '{1'b0, 1'b0, 1'b1, 1'b1, TOP_CAPTURE, CNT_MAX, EV_TOP, EV_BOTTOM};
         4'hB: d = '{1'b0, 1'b0, 1'b1, 1'b1, TOP_MATCH_A, CNT_MAX, EV_TOP, EV_BOTTOM};
         4'hC: d.top_src = TOP_CAPTURE;
         4'hE: d = '{1'b0, 1'b1, 1'b0, 1'b1, TOP_CAPTURE, CNT_MAX, EV_TOP, EV_TOP};
         4'hF: d = '{1'b0, 1'b1, 1'b0, 1'b1, TOP_MATCH_A, CNT_MAX, EV_TOP, EV_TOP};
      endcase
      return d;
   endfunction

endpackage

// >>> core/tmw_timer_wave.sv
// The address map and the APB slave port were decided locally.
module tmw_timer_wave (
   // Clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_N_I,
   // APB slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // Port data used when a pin is not overridden
   input  wire logic        PORT_A_DATA_I,
   input  wire logic        PORT_B_DATA_I,
   // Compare output pins
   output logic             TIMER1_CHAN_A_WAVE_OUT_O,
   output logic             TIMER1_CHAN_A_WAVE_OE_O,
   output logic             TIMER1_CHAN_B_WAVE_OUT_O,
   output logic             TIMER1_CHAN_B_WAVE_OE_O,
   // Interrupt
   output logic             IRQ_O
);

   // ==========================================================
   // Declarations
   // ==========================================================
   logic [7:0]          timer1_control_a_q;
   logic [1:0]          waveform_mode_high_bits_q;
   logic [15:0]         match_buf_q [2];
   logic [15:0]         match_act_q [2];
   logic [15:0]         capture_value_reg_q;
   logic [15:0]         counter_value_q;
   logic [15:0]         counter_value_d;
   tmw_pkg::tmw_dir_t   dir_q;
   tmw_pkg::tmw_dir_t   dir_d;
   logic [2:0]          int_stat_q;
   logic [2:0]          int_mask_q;
   logic [1:0]          pin_dir_q;
   logic [1:0]          wave_q;
   logic [1:0]          pin_q;
   logic [1:0]          pin_oe_q;
   logic [31:0]         prdata_q;

   // ==========================================================
   // APB decode
   // ==========================================================
   wire logic wr_en       = PSEL_I & PENABLE_I & PWRITE_I;
   wire logic rd_en       = PSEL_I & PENABLE_I & ~PWRITE_I;
   wire logic setup       = PSEL_I & ~PENABLE_I;
   wire logic sel_ctrl_a  = PADDR_I == tmw_pkg::ADDR_CTRL_A;
   wire logic sel_ctrl_b  = PADDR_I == tmw_pkg::ADDR_CTRL_B;
   wire logic sel_match_a = PADDR_I == tmw_pkg::ADDR_MATCH_A;
   wire logic sel_match_b = PADDR_I == tmw_pkg::ADDR_MATCH_B;
   wire logic sel_capture = PADDR_I == tmw_pkg::ADDR_CAPTURE;
   wire logic sel_counter = PADDR_I == tmw_pkg::ADDR_COUNTER;
   wire logic sel_stat    = PADDR_I == tmw_pkg::ADDR_INT_STAT;
   wire logic sel_mask    = PADDR_I == tmw_pkg::ADDR_INT_MASK;
   wire logic sel_pin_dir = PADDR_I == tmw_pkg::ADDR_PIN_DIR;
   wire logic sel_any     = sel_ctrl_a | sel_ctrl_b | sel_match_a | sel_match_b | sel_capture
                          | sel_counter | sel_stat | sel_mask | sel_pin_dir;

   // Zero wait states; unmapped addresses answer with an error
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~sel_any;
   assign PRDATA_O  = prdata_q;

   // Read mux, sampled in the setup phase so read data comes from a flop
   wire logic [31:0] rd_mux =
        sel_ctrl_a  ? {24'h000000, timer1_control_a_q}
      : sel_ctrl_b  ? {24'h000000, 3'h0, waveform_mode_high_bits_q, 3'h0}
      : sel_match_a ? {16'h0000, match_buf_q[0]}
      : sel_match_b ? {16'h0000, match_buf_q[1]}
      : sel_capture ? {16'h0000, capture_value_reg_q}
      : sel_counter ? {16'h0000, counter_value_q}
      : sel_stat    ? {29'h00000000, int_stat_q}
      : sel_mask    ? {29'h00000000, int_mask_q}
      : sel_pin_dir ? {30'h00000000, pin_dir_q}
      : 32'h00000000;

   // ==========================================================
   // Mode decode
   // ==========================================================
   // mode assembly
   wire logic [3:0] waveform_mode_select = {waveform_mode_high_bits_q, timer1_control_a_q[1:0]};
   wire tmw_pkg::tmw_mode_t mode = tmw_pkg::tmw_decode(waveform_mode_select);
   wire logic [1:0] chan_a_output_mode = timer1_control_a_q[tmw_pkg::CA_MODE_A_LSB +: 2];
   wire logic [1:0] chan_b_output_mode = timer1_control_a_q[tmw_pkg::CA_MODE_B_LSB +: 2];
   wire logic [1:0] out_mode [2];
   assign out_mode[0] = chan_a_output_mode;
   assign out_mode[1] = chan_b_output_mode;

   // TOP source selection; the match A register used is the active copy
   // TOP source
   wire logic [15:0] top_val =
        (mode.top_src == tmw_pkg::TOP_MATCH_A) ? match_act_q[0]
      : (mode.top_src == tmw_pkg::TOP_CAPTURE) ? capture_value_reg_q
      : mode.top_fixed;

   wire logic at_top  = counter_value_q == top_val;
   wire logic at_bot  = counter_value_q == tmw_pkg::CNT_BOTTOM;
   wire logic at_max  = counter_value_q == tmw_pkg::CNT_MAX;
   wire logic counting_up = dir_q == tmw_pkg::DIR_UP;

   // ==========================================================
   // Counter sequencing
   // ==========================================================
   // TOP held one cycle
   // In dual slope the counter sits on TOP for one cycle, then steps down.
   // A TOP below the count while up just wraps through MAX like hardware would.
   always_comb begin
      counter_value_d = counter_value_q + 16'h0001;
      dir_d           = dir_q;
      if (mode.dual) begin
         unique case (dir_q)
            tmw_pkg::DIR_UP: begin
               if (at_top) begin
                  counter_value_d = counter_value_q - 16'h0001;
                  dir_d           = tmw_pkg::DIR_DOWN;
               end
            end
            tmw_pkg::DIR_DOWN: begin
               if (at_bot) begin
                  dir_d = tmw_pkg::DIR_UP;
               end else begin
                  counter_value_d = counter_value_q - 16'h0001;
               end
            end
         endcase
      end else begin
         dir_d = tmw_pkg::DIR_UP;
         if (at_top) begin
            counter_value_d = tmw_pkg::CNT_BOTTOM;
         end
      end
   end

   // Counter and direction; a software write replaces the count
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         counter_value_q <= tmw_pkg::CNT_BOTTOM;
         dir_q           <= tmw_pkg::DIR_UP;
      end else begin
         counter_value_q <= (wr_en && sel_counter) ? PWDATA_I[15:0] : counter_value_d;
         dir_q           <= dir_d;
      end
   end

   // ==========================================================
   // Update and wrap events
   // ==========================================================
   // update point
   wire logic update_now =
        (mode.update_at == tmw_pkg::EV_NOW)
      | ((mode.update_at == tmw_pkg::EV_TOP) & at_top)
      | ((mode.update_at == tmw_pkg::EV_BOTTOM) & at_bot);

   // Wrap at BOTTOM only fires when turning, not at reset start
   // wrap flag point
   wire logic wrap_evt =
        ((mode.wrap_at == tmw_pkg::EV_MAX) & at_max)
      | ((mode.wrap_at == tmw_pkg::EV_TOP) & at_top)
      | ((mode.wrap_at == tmw_pkg::EV_BOTTOM) & at_bot & ~counting_up);

   // ==========================================================
   // Software registers
   // ==========================================================
   // reserved bits masked
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         timer1_control_a_q        <= tmw_pkg::CTRL_A_RESET;
         waveform_mode_high_bits_q <= tmw_pkg::CTRL_B_RESET;
         capture_value_reg_q       <= tmw_pkg::CNT_BOTTOM;
         int_mask_q                <= tmw_pkg::IRQ_RESET;
         pin_dir_q                 <= 2'h0;
      end else if (wr_en) begin
         if (sel_ctrl_a) begin
            timer1_control_a_q <= PWDATA_I[7:0] & tmw_pkg::CTRL_A_WMASK;
         end
         if (sel_ctrl_b) begin
            waveform_mode_high_bits_q <= PWDATA_I[tmw_pkg::CB_HIGH_LSB +: 2];
         end
         if (sel_capture) begin
            capture_value_reg_q <= PWDATA_I[15:0];
         end
         if (sel_mask) begin
            int_mask_q <= PWDATA_I[2:0];
         end
         if (sel_pin_dir) begin
            pin_dir_q <= PWDATA_I[1:0];
         end
      end
   end

   // Read data captured in setup phase; stable through the access phase
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Compare channels
   // ==========================================================
   logic [1:0] match_hit;
   logic [1:0] wave_d;
   logic [1:0] override;

   for (genvar i = 0; i < 2; i++) begin : g_chan
      wire logic chan_a   = (i == 0);
      wire logic wr_match = wr_en & ((i == 0) ? sel_match_a : sel_match_b);
      wire logic ocr_top  = match_act_q[i] == top_val;
      wire logic ocr_bot  = match_act_q[i] == tmw_pkg::CNT_BOTTOM;
      wire logic mode_01  = out_mode[i] == 2'b01;
      // Toggle allowed in non-PWM always, in PWM only for A in listed modes
      wire logic tog_ok   = mode.nonpwm | (chan_a & mode.toggle_ok);

      assign match_hit[i] = counter_value_q == match_act_q[i];
      assign override[i]  = (out_mode[i] != 2'b00) & ~(mode_01 & ~tog_ok);

      // Buffer written by software; active copy loaded at the update point
      always_ff @(posedge CORE_CLK_I) begin
         if (!RST_N_I) begin
            match_buf_q[i] <= tmw_pkg::CNT_BOTTOM;
            match_act_q[i] <= tmw_pkg::CNT_BOTTOM;
         end else begin
            if (wr_match) begin
               match_buf_q[i] <= PWDATA_I[15:0];
            end
            if (update_now) begin
               match_act_q[i] <= match_buf_q[i];
            end
         end
      end

      // Next output level per mode class
      always_comb begin
         wave_d[i] = wave_q[i];
         if (mode_01) begin
            if (match_hit[i] && tog_ok) begin
               wave_d[i] = ~wave_q[i];
            end
         end else if (out_mode[i][1]) begin
            if (mode.nonpwm) begin
               if (match_hit[i]) begin
                  wave_d[i] = out_mode[i][0];
               end
            end else if (mode.fast) begin
               if (at_top) begin
                  wave_d[i] = ~out_mode[i][0];
               end else if (match_hit[i] && !ocr_top) begin
                  wave_d[i] = out_mode[i][0];
               end
            end else begin
               if (ocr_bot) begin
                  wave_d[i] = out_mode[i][0];
               end else if (ocr_top) begin
                  wave_d[i] = ~out_mode[i][0];
               end else if (match_hit[i]) begin
                  wave_d[i] = counting_up ? out_mode[i][0] : ~out_mode[i][0];
               end
            end
         end
      end
   end

   // Waveform state and registered pin drive
   // direction gates driver
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         wave_q   <= 2'h0;
         pin_q    <= 2'h0;
         pin_oe_q <= 2'h0;
      end else begin
         wave_q   <= wave_d;
         pin_q[0] <= override[0] ? wave_q[0] : PORT_A_DATA_I;
         pin_q[1] <= override[1] ? wave_q[1] : PORT_B_DATA_I;
         pin_oe_q <= pin_dir_q;
      end
   end

   assign TIMER1_CHAN_A_WAVE_OUT_O = pin_q[0];
   assign TIMER1_CHAN_A_WAVE_OE_O  = pin_oe_q[0];
   assign TIMER1_CHAN_B_WAVE_OUT_O = pin_q[1];
   assign TIMER1_CHAN_B_WAVE_OE_O  = pin_oe_q[1];

   // ==========================================================
   // Interrupt status
   // ==========================================================
   // Sticky status; a read clears, but an event in the same cycle wins
   wire logic [2:0] int_evt = {match_hit[1], match_hit[0], wrap_evt};
   wire logic       stat_rd = rd_en & sel_stat;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         int_stat_q <= tmw_pkg::IRQ_RESET;
      end else begin
         int_stat_q <= (stat_rd ? 3'h0 : int_stat_q) | int_evt;
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign IRQ_O = |(int_stat_q & int_mask_q);

endmodule

// >>> dv/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready, pslverr, out_a, oe_a, out_b, oe_b, irq, pin_a, pin_b, rerr;
   logic        port_a = 1'b0;
   logic        port_b = 1'b0;
   int          error_cnt = 0;
   int          check_count = 0;
   tmw_timer_wave dut_u (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .PORT_A_DATA_I(port_a), .PORT_B_DATA_I(port_b), .TIMER1_CHAN_A_WAVE_OUT_O(out_a),
      .TIMER1_CHAN_A_WAVE_OE_O(oe_a), .TIMER1_CHAN_B_WAVE_OUT_O(out_b), .TIMER1_CHAN_B_WAVE_OE_O(oe_b),
      .IRQ_O(irq));
   tmw_load_model load_u (.out_a_i(out_a), .oe_a_i(oe_a), .out_b_i(out_b), .oe_b_i(oe_b),
      .pin_a_o(pin_a), .pin_b_o(pin_b));
   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   // One APB transfer; the request holds until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         error_cnt++;
         $display("BAD %0t no ready", $time);
         stop_test();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Program a mode, let buffers settle, then count high cycles of pin A
   task automatic run(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] ma, input int n, input int exp);
      int h;
      h = 0;
      // Low bits cleared first so no write pair ever passes through mode 13
      apb(1'b1, tmw_pkg::ADDR_CTRL_A, 32'h0);
      apb(1'b1, tmw_pkg::ADDR_CTRL_B, {24'h0, cb});
      apb(1'b1, tmw_pkg::ADDR_CAPTURE, 32'h9);
      apb(1'b1, tmw_pkg::ADDR_MATCH_A, {16'h0, ma});
      apb(1'b1, tmw_pkg::ADDR_CTRL_A, {24'h0, ca});
      apb(1'b1, tmw_pkg::ADDR_COUNTER, 32'h0);
      wait_cyc(1100);
      repeat (n) begin
         @(negedge core_clk);
         if (pin_a === 1'b1) h++;
      end
      check(h, exp, "high cycles");
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs();
      apb(1'b0, tmw_pkg::ADDR_CTRL_A, 32'h0);
      check(rd, 32'h0, "control A reset");
      apb(1'b1, tmw_pkg::ADDR_CTRL_A, 32'hFF);
      apb(1'b0, tmw_pkg::ADDR_CTRL_A, 32'h0);
      check(rd, 32'hF3, "control A read-only bits");
      apb(1'b0, 8'h40, 32'h0);
      check({31'h0, rerr}, 32'h1, "unmapped error");
      apb(1'b1, tmw_pkg::ADDR_CTRL_A, 32'h0);
   endtask
   task automatic t_pins();
      port_a <= 1'b1;
      apb(1'b1, tmw_pkg::ADDR_PIN_DIR, 32'h3);
      wait_cyc(3);
      check({30'h0, pin_b, pin_a}, 32'h1, "port to pins");
      port_a <= 1'b0;
      port_b <= 1'b1;
      wait_cyc(3);
      check({30'h0, pin_b, pin_a}, 32'h2, "port to pins swapped");
      apb(1'b1, tmw_pkg::ADDR_PIN_DIR, 32'h0);
      wait_cyc(3);
      check({30'h0, pin_b, pin_a}, 32'h0, "inputs not driven");
      port_a <= 1'b1;
      port_b <= 1'b0;
      apb(1'b1, tmw_pkg::ADDR_PIN_DIR, 32'h3);
   endtask
   task automatic t_irq();
      apb(1'b1, tmw_pkg::ADDR_CTRL_B, 32'h0);
      apb(1'b1, tmw_pkg::ADDR_INT_MASK, 32'h0);
      apb(1'b0, tmw_pkg::ADDR_INT_STAT, 32'h0);
      apb(1'b1, tmw_pkg::ADDR_COUNTER, 32'hFFF0);
      wait_cyc(40);
      check({31'h0, irq}, 32'h0, "masked wrap");
      apb(1'b1, tmw_pkg::ADDR_INT_MASK, 32'h1);
      @(negedge core_clk);
      check({31'h0, irq}, 32'h1, "wrap interrupt");
      apb(1'b0, tmw_pkg::ADDR_INT_STAT, 32'h0);
      check({31'h0, rd[0]}, 32'h1, "wrap status");
      @(negedge core_clk);
      check({31'h0, irq}, 32'h0, "status cleared");
   endtask
   task automatic t_nonpwm();
      run(8'h40, 8'h08, 16'h9, 20, 10);
      run(8'hC0, 8'h08, 16'h9, 20, 20);
      run(8'h80, 8'h08, 16'h9, 20, 0);
      run(8'h40, 8'h18, 16'h9, 20, 10);
   endtask
   task automatic t_fast();
      run(8'h81, 8'h08, 16'h40, 256, 65);
      run(8'hC1, 8'h08, 16'h40, 256, 191);
      run(8'h81, 8'h08, 16'hFF, 256, 256);
      run(8'h41, 8'h08, 16'h40, 256, 256);
      run(8'h87, 8'h08, 16'h40, 1024, 65);
      run(8'h43, 8'h18, 16'h9, 20, 10);
      run(8'h82, 8'h18, 16'h4, 20, 10);
   endtask
   // Channel B waveform, fast 8-bit, clear on match and set at TOP
   task automatic t_chan_b();
      int h;
      h = 0;
      apb(1'b1, tmw_pkg::ADDR_MATCH_B, 32'h40);
      run(8'hA1, 8'h08, 16'h40, 256, 65);
      repeat (256) begin
         @(negedge core_clk);
         if (pin_b === 1'b1) h++;
      end
      check(h, 65, "chan B high cycles");
   endtask
   task automatic t_dual();
      run(8'h81, 8'h00, 16'h40, 510, 128);
      run(8'hC1, 8'h00, 16'h40, 510, 382);
      run(8'h81, 8'h00, 16'h00, 510, 0);
      run(8'h81, 8'h00, 16'hFF, 510, 510);
      run(8'h41, 8'h00, 16'h40, 510, 510);
      run(8'h83, 8'h00, 16'h40, 2046, 128);
      run(8'h80, 8'h10, 16'h4, 18, 8);
      run(8'h41, 8'h10, 16'h9, 36, 18);
      run(8'h82, 8'h10, 16'h4, 18, 8);
      run(8'h43, 8'h10, 16'h9, 36, 18);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_pins();
      t_irq();
      t_nonpwm();
      t_fast();
      t_chan_b();
      t_dual();
      stop_test();
   end
endmodule
bind tmw_timer_wave tmw_timer_wave_chk chk_u (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PORT_A_DATA_I(PORT_A_DATA_I), .PORT_B_DATA_I(PORT_B_DATA_I),
   .TIMER1_CHAN_A_WAVE_OUT_O(TIMER1_CHAN_A_WAVE_OUT_O), .TIMER1_CHAN_A_WAVE_OE_O(TIMER1_CHAN_A_WAVE_OE_O),
   .TIMER1_CHAN_B_WAVE_OUT_O(TIMER1_CHAN_B_WAVE_OUT_O), .TIMER1_CHAN_B_WAVE_OE_O(TIMER1_CHAN_B_WAVE_OE_O),
   .IRQ_O(IRQ_O));

// >>> dv/tmw_load_model.sv
module tmw_load_model (
   // Pin drivers from the timer
   input  wire logic out_a_i,
   input  wire logic oe_a_i,
   input  wire logic out_b_i,
   input  wire logic oe_b_i,
   // Levels seen by the load
   output logic      pin_a_o,
   output logic      pin_b_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pull-down on each pin, so an undriven pin never shows the last driven level
   assign pin_a_o = oe_a_i ? out_a_i : 1'b0;
   assign pin_b_o = oe_b_i ? out_b_i : 1'b0;
endmodule

// >>> dv/tmw_timer_wave_chk.sv
module tmw_timer_wave_chk (
   // Clock and reset
   input wire logic        CORE_CLK_I,
   input wire logic        RST_N_I,
   // APB
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   // Pins and interrupt
   input wire logic        PORT_A_DATA_I,
   input wire logic        PORT_B_DATA_I,
   input wire logic        TIMER1_CHAN_A_WAVE_OUT_O,
   input wire logic        TIMER1_CHAN_A_WAVE_OE_O,
   input wire logic        TIMER1_CHAN_B_WAVE_OUT_O,
   input wire logic        TIMER1_CHAN_B_WAVE_OE_O,
   input wire logic        IRQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sha_q;
   logic [7:0] shb_q;
   logic [1:0] age_q;
   logic       wr_en;
   logic       rd_en;
   logic [3:0] mode;
   logic       pwm;
   logic       pass_a;
   logic       pass_b;
   logic       unmapped;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // ==========================================================
   // Shadow of the mode registers
   // ==========================================================
   // Decode of the shadow; in PWM modes toggle on A is kept only in modes 8-11, 14 and 15
   assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd_en    = PSEL_I & PENABLE_I & !PWRITE_I;
   assign mode     = {shb_q[4:3], sha_q[1:0]};
   assign pwm      = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
   assign pass_a   = sha_q[7:6] == 2'h0 || (sha_q[7:6] == 2'h1 && pwm && !(mode inside {[4'h8:4'hB], 4'hE, 4'hF}));
   assign pass_b   = sha_q[5:4] == 2'h0 || (sha_q[5:4] == 2'h1 && pwm);
   assign unmapped = PADDR_I > tmw_pkg::ADDR_PIN_DIR || PADDR_I[1:0] != 2'h0;
   // Age counts edges since a mode write, so checks skip the settling cycles
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         sha_q <= 8'h00;
         shb_q <= 8'h00;
         age_q <= 2'h0;
      end else begin
         if (wr_en && PADDR_I == tmw_pkg::ADDR_CTRL_A) sha_q <= PWDATA_I[7:0];
         if (wr_en && PADDR_I == tmw_pkg::ADDR_CTRL_B) shb_q <= PWDATA_I[7:0];
         age_q <= (wr_en && PADDR_I inside {tmw_pkg::ADDR_CTRL_A, tmw_pkg::ADDR_CTRL_B}) ? 2'h0 :
                  (age_q == 2'h3) ? age_q : age_q + 2'h1;
      end
   end
   // ==========================================================
   // Assertions
   // ==========================================================
   property p_pass_a;
      age_q == 2'h3 && pass_a |-> TIMER1_CHAN_A_WAVE_OUT_O == $past(PORT_A_DATA_I);
   endproperty
   a_pass_a: assert property (p_pass_a) else $error("pin A not following port data");
   property p_pass_b;
      age_q == 2'h3 && pass_b |-> TIMER1_CHAN_B_WAVE_OUT_O == $past(PORT_B_DATA_I);
   endproperty
   a_pass_b: assert property (p_pass_b) else $error("pin B not following port data");
   property p_dir;
      wr_en && PADDR_I == tmw_pkg::ADDR_PIN_DIR |->
         ##2 {TIMER1_CHAN_B_WAVE_OE_O, TIMER1_CHAN_A_WAVE_OE_O} == $past(PWDATA_I[1:0], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("pin enables differ from direction");
   property p_set_hold;
      age_q == 2'h3 && !pwm && sha_q[7:6] == 2'h3 && TIMER1_CHAN_A_WAVE_OUT_O |=> TIMER1_CHAN_A_WAVE_OUT_O;
   endproperty
   a_set_hold: assert property (p_set_hold) else $error("set-on-match output fell");
   property p_clr_hold;
      age_q == 2'h3 && !pwm && sha_q[7:6] == 2'h2 && !TIMER1_CHAN_A_WAVE_OUT_O |=> !TIMER1_CHAN_A_WAVE_OUT_O;
   endproperty
   a_clr_hold: assert property (p_clr_hold) else $error("clear-on-match output rose");
   property p_ctla_rd;
      rd_en && PADDR_I == tmw_pkg::ADDR_CTRL_A |-> PRDATA_O[7:0] == (sha_q & tmw_pkg::CTRL_A_WMASK);
   endproperty
   a_ctla_rd: assert property (p_ctla_rd) else $error("control A read value wrong");
   property p_err;
      PSEL_I && PENABLE_I |-> PSLVERR_O == unmapped;
   endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_ready;
      PSEL_I && PENABLE_I |-> PREADY_O;
   endproperty
   a_ready: assert property (p_ready) else $error("access not answered");
endmodule
